/* File: dv/fspd_fan_model.sv */
// Fan tachometer model: square wave, single pulses and held levels
`timescale 1ns/1ns
module fspd_fan_model #(
    parameter HALF_NS = 1000
) (
    output logic speed_out
);
    initial speed_out = 1'b0;
    // Whole periods of a 50% duty wave, each starting high and ending low
    task periods(input int n);
        for (int i = 0; i < n; i++) begin
            speed_out = 1'b1;
            #HALF_NS;
            speed_out = 1'b0;
            #HALF_NS;
        end
    endtask
    // Single high pulse, used as a glitch when narrow
    task pulse(input int w);
        speed_out = 1'b1;
        #w;
        speed_out = 1'b0;
    endtask
    // Stuck level, as a locked rotor output would give
    task level(input logic b);
        speed_out = b;
    endtask
endmodule // fspd_fan_model

/* File: dv/fspd_monitor_sva.sv */
// Checker for the fan speed monitor register port and outputs
`timescale 1ns/1ns
module fspd_monitor_sva (
    input wire        core_clk_in,
    input wire        srst_in,
    input wire [7:0]  reg_addr_in,
    input wire        reg_wr_in,
    input wire        reg_rd_in,
    input wire [31:0] reg_wdata_in,
    input wire [31:0] reg_rdata_out,
    input wire        reg_rvalid_out,
    input wire        irq_out
,   input wire        speed_pin_ie_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    // Control write, then a cycle with no further control write
    sequence ctl_wr;
        reg_wr_in && reg_addr_in == 8'h00;
    endsequence
    sequence ctl_quiet;
        !(reg_wr_in && reg_addr_in == 8'h00);
    endsequence
    chk_rd_answer: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("read got no answer");
    chk_rdata_idle: assert property (!reg_rvalid_out |-> reg_rdata_out == 32'h0)
        else $error("read data not zero when idle");
    chk_reset_quiet: assert property ($fell(srst_in) |-> !irq_out && !speed_pin_ie_out)
        else $error("outputs active after reset");
    chk_enable_pin: assert property (ctl_wr ##1 ctl_quiet |=>
        speed_pin_ie_out == $past(reg_wdata_in[1], 2))
        else $error("pin enable does not follow enable bit");
    chk_irq_fall: assert property ($fell(irq_out) |->
        $past(reg_wr_in) || $past(reg_wr_in, 2) || $past(reg_wr_in, 3))
        else $error("interrupt dropped without a write");
    chk_limit_upper: assert property (reg_rd_in && reg_addr_in[7:3] == 5'h01 |=>
        reg_rdata_out[31:16] == 16'h0)
        else $error("limit upper bits not zero");
    chk_status_rsvd: assert property (reg_rd_in && reg_addr_in == 8'h04 |=>
        reg_rdata_out[31:4] == 28'h0)
        else $error("status reserved bits not zero");
    chk_unmapped: assert property (reg_rd_in && (reg_addr_in[1:0] != 2'h0 ||
        reg_addr_in > 8'h0c) |=> reg_rdata_out == 32'h0)
        else $error("unmapped read not zero");
    chk_ctl_rsvd: assert property (reg_rd_in && reg_addr_in == 8'h00 |=>
        reg_rdata_out[7:2] == 6'h0 && !reg_rdata_out[9] && !reg_rdata_out[13])
        else $error("control reserved bits not zero");
endmodule // fspd_monitor_sva

bind fspd_monitor fspd_monitor_sva u_sva (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .irq_out(irq_out),
    .speed_pin_ie_out(speed_pin_ie_out));

/* File: dv/test_fan_speed_monitor.sv */
// Self-checking testbench of the fan speed monitor
`timescale 1ns/1ns
module test_fan_speed_monitor;
    logic        clk;
    logic        srst;
    logic        cclk;
    logic [7:0]  addr;
    logic        wr;
    logic        rd_s;
    logic [31:0] wdata;
    logic [31:0] v;
    wire  [31:0] rdata;
    wire         rvalid, irq, pin_ie, pin;
    int          error_cnt = 0;
    int          samples_checked = 0;
    // 100 MHz core clock; slow count clock of 200 ns keeps intervals short
    always #5 clk = ~clk;
    always #100 cclk = ~cclk;
    fspd_fan_model fan (.speed_out(pin));
    fspd_monitor uut (.core_clk_in(clk), .srst_in(srst),
        .speed_pin_in(pin), .count_clk_in(cclk), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_rd_in(rd_s), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid), .irq_out(irq), .speed_pin_ie_out(pin_ie));
    task give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Range compare: tick counts depend on phase of the count clock
    task chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        samples_checked++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(negedge clk);
        addr = a;
        rd_s = 1'b1;
        @(negedge clk);
        // Answer stands for exactly one cycle after the strobe edge
        d = rdata;
        chk({31'h0, rvalid}, 32'h1);
        rd_s = 1'b0;
    endtask
    task wait_ready;
        int k;
        wr_reg(8'h04, 32'h8);
        for (k = 0; k < 3000; k++) begin
            rd_reg(8'h04, v);
            if (v[3] === 1'b1)
                break;
        end
        if (k == 3000) begin
            error_cnt++;
            give_verdict;
        end
    endtask
    task t_defaults;
        rd_reg(8'h00, v);
        chk(v, 32'h0);
        rd_reg(8'h04, v);
        chk(v, 32'h0);
        rd_reg(8'h08, v);
        chk(v, 32'hffff);
        rd_reg(8'h0c, v);
        chk(v, 32'h0);
        rd_reg(8'h10, v);
        chk(v, 32'h0);
        chk({31'h0, pin_ie}, 32'h0);
        $display("test defaults done");
    endtask
    task t_edge_mode;
        wr_reg(8'h0c, 32'h0100);
        wr_reg(8'h00, 32'h2);
        repeat (2) @(negedge clk);
        chk({31'h0, pin_ie}, 32'h1);
        fan.periods(6);
        repeat (10) @(negedge clk);
        rd_reg(8'h00, v);
        chk(v >> 16, 32'h6);
        rd_reg(8'h04, v);
        chk(v, 32'h5);
        chk({31'h0, irq}, 32'h0);
        wr_reg(8'h00, 32'h3);
        repeat (3) @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        wr_reg(8'h04, 32'h5);
        repeat (3) @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        rd_reg(8'h04, v);
        chk(v, 32'h0);
        fan.level(1'b1);
        repeat (10) @(negedge clk);
        rd_reg(8'h04, v);
        chk(v, 32'h7);
        fan.level(1'b0);
        wr_reg(8'h0c, 32'h0);
        $display("test edge mode done");
    endtask
    task t_disable;
        wr_reg(8'h00, 32'h0);
        repeat (2) @(negedge clk);
        chk({31'h0, pin_ie}, 32'h0);
        fan.periods(3);
        rd_reg(8'h00, v);
        chk(v >> 16, 32'h7);
        wr_reg(8'h00, 32'h2);
        fan.periods(1);
        repeat (10) @(negedge clk);
        rd_reg(8'h00, v);
        chk(v >> 16, 32'h8);
        $display("test disable done");
    endtask
    task t_filter;
        // Let the filtered level settle low before it takes over the input
        repeat (100) @(negedge clk);
        wr_reg(8'h04, 32'h7);
        wr_reg(8'h00, 32'h102);
        repeat (10) @(negedge clk);
        fan.pulse(300);
        repeat (100) @(negedge clk);
        rd_reg(8'h00, v);
        chk(v >> 16, 32'h8);
        rd_reg(8'h04, v);
        chk(v & 32'h4, 32'h0);
        fan.pulse(2000);
        repeat (100) @(negedge clk);
        rd_reg(8'h00, v);
        chk(v >> 16, 32'h9);
        $display("test filter done");
    endtask
    // Each interval spans edges minus one half periods of five ticks
    task t_clock_mode;
        int n;
        wr_reg(8'h08, 32'h3);
        wr_reg(8'h04, 32'h1);
        for (int c = 0; c < 4; c++) begin
            n = (c == 0) ? 2 : (c == 1) ? 3 : (c == 2) ? 5 : 9;
            wr_reg(8'h00, 32'h402 | (c << 11));
            fork
                fan.periods(2 * n + 2);
                begin
                    wait_ready;
                    wait_ready;
                    rd_reg(8'h00, v);
                    chk_rng(v >> 16, (n - 1) * 5 - 2, (n - 1) * 5 + 2);
                    rd_reg(8'h04, v);
                    chk(v & 32'h8, 32'h8);
                end
            join
        end
        wr_reg(8'h00, 32'h2);
        rd_reg(8'h04, v);
        chk(v & 32'h9, 32'h1);
        wr_reg(8'h08, 32'hffff);
        $display("test clock mode done");
    endtask
    initial begin
        clk = 1'b0;
        srst = 1'b1;
        cclk = 1'b0;
        addr = 8'h00;
        wr = 1'b0;
        rd_s = 1'b0;
        wdata = 32'h0;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        t_defaults;
        t_edge_mode;
        t_disable;
        t_filter;
        t_clock_mode;
        give_verdict;
    end
endmodule // test_fan_speed_monitor

/* File: shared/fspd_consts.vh */
// Register offsets, field positions, reset values and counts of the fan speed monitor
`ifndef FSPD_CONSTS_VH
`define FSPD_CONSTS_VH

// Register byte offsets on the controller peripheral bus
`define FSPD_OFS_CTRL        8'h00
`define FSPD_OFS_STATUS      8'h04
`define FSPD_OFS_HIGH        8'h08
`define FSPD_OFS_LOW         8'h0c

// Control register fields
`define FSPD_CTL_LIMIT_IE    0
`define FSPD_CTL_ENABLE      1
`define FSPD_CTL_FILTER      8
`define FSPD_CTL_MODE        10
`define FSPD_CTL_EDGES_LO    11
`define FSPD_CTL_EDGES_HI    12
`define FSPD_CTL_READY_IE    14
`define FSPD_CTL_TOGGLE_IE   15
`define FSPD_CTL_READ_LO     16
`define FSPD_CTL_READ_HI     31

// Status register fields
`define FSPD_ST_LIMIT        0
`define FSPD_ST_PIN          1
`define FSPD_ST_TOGGLE       2
`define FSPD_ST_READY        3

// Reset values and counter maximum
`define FSPD_RST_CTRL        16'h0000
`define FSPD_RST_HIGH        16'hffff
`define FSPD_RST_LOW         16'h0000
`define FSPD_RST_COUNT       16'h0000
`define FSPD_CNT_MAX         16'hffff

// Interval lengths in input edges for each edge code
`define FSPD_EDGES_C0        4'h2
`define FSPD_EDGES_C1        4'h3
`define FSPD_EDGES_C2        4'h5
`define FSPD_EDGES_C3        4'h9

// Glitch filter width in slow count clock periods
`define FSPD_FILT_TICKS      3

`endif

/* File: src/fspd_glitch_filter.v */
// Glitch filter: passes a level only after it has held for a number of slow ticks
`timescale 1ns/1ns
module fspd_glitch_filter #(
    parameter TICKS = 3
) (
    input  wire core_clk_in,
    input  wire srst_in,
    input  wire run_in,
    input  wire tick_in,
    input  wire level_in,
    output wire level_out
);
    reg [3:0] held_r;
    reg       level_r;

    assign level_out = level_r;

    // Count ticks while the raw level differs; a narrower pulse restarts the count
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            held_r  <= 4'h0;
            level_r <= 1'b0;
        end else if (run_in) begin
            if (level_in == level_r) begin
                held_r <= 4'h0;
            end else if (tick_in) begin
                if (held_r == TICKS[3:0] - 4'h1) begin
                    level_r <= level_in;
                    held_r  <= 4'h0;
                end else begin
                    held_r <= held_r + 4'h1;
                end
            end
        end
    end
endmodule // fspd_glitch_filter

/* File: src/fspd_monitor.v */
// Fan speed monitor: speed input capture, counters, limits, status and registers
`timescale 1ns/1ns
`include "fspd_consts.vh"

// Functional notes
// RULE1: Out-of-limit status reaches the interrupt only while its enable bit is 1.
// RULE2: Enable bit 0 keeps the block idle, clocks gated, speed pin not driven.
// RULE3: Re-enabling resumes counters where they stopped; pending status stays.
// RULE4: Firmware ignores status and reading until one update follows enabling.
// RULE5: Filter enable rejects input pulses narrower than three slow clock periods.
// RULE6: Mode 0 counts each low-to-high transition of the speed input.
// RULE7: Mode 1 counts slow clock edges, latches and clears after programmed edges.
// RULE8: Edge code 00,01,10,11 selects intervals of 2,3,5,9 input edges.
// RULE9: Mode 0 copies the count to the reading each increment, wraps FFFFh to 0.
// RULE10: Mode 1 also latches and clears when the counter reaches FFFFh.
// RULE11: Firmware may set high limit below FFFFh to catch a stuck fan.
// RULE12: Status bit 0 sets when reading is above high or below low; W1C.
// RULE13: Status bit 1 reads the present speed input level.
// RULE14: Status bit 2 sets on either input transition; W1C; gated into interrupt.
// RULE15: Ready status stays 0 whenever mode select is 0.
// RULE16: Mode 1 sets ready status bit 3 on each latch; W1C; gated into interrupt.
// RULE17: High limit is 16 bits, resets to FFFFh, FFFFh means no above-limit event.
// RULE18: Firmware reads status at start since an active input gives no toggle.
// RULE19: Reading below 16-bit low limit sets out-of-limit; 0000h disables it.
// RULE20: One interrupt output is the OR of each status bit and its enable.
// RULE21: System reset returns control, status, limits and counters to defaults.
module fspd_monitor #(
    parameter FILT_TICKS = `FSPD_FILT_TICKS
) (
    input  wire        core_clk_in,
    input  wire        srst_in,
    input  wire        speed_pin_in,
    input  wire        count_clk_in,
    input  wire [7:0]  reg_addr_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    input  wire [31:0] reg_wdata_in,
    output reg  [31:0] reg_rdata_out,
    output reg         reg_rvalid_out,
    output reg         irq_out,
    output reg         speed_pin_ie_out
);
    // Control and limit storage
    reg        limit_ie_r;
    reg        enable_r;
    reg        filter_r;
    reg        mode_r;
    reg [1:0]  edges_r;
    reg        ready_ie_r;
    reg        toggle_ie_r;
    reg [15:0] high_r;
    reg [15:0] low_r;

    // Counting state
    reg [15:0] count_r;
    reg [15:0] count_nxt;
    reg [15:0] reading_r;
    reg [15:0] reading_nxt;
    reg [3:0]  edge_seen_r;
    reg [3:0]  edge_seen_nxt;
    reg        latch_evt;

    // Status bits
    reg        st_limit_r;
    reg        st_toggle_r;
    reg        st_ready_r;

    // Synchronisers for the two outside inputs
    reg  [2:0] pin_sync_r;
    reg  [2:0] clk_sync_r;
    reg        pin_lvl_r;
    reg        clk_lvl_r;
    reg        speed_prev_r;

    wire       pin_lvl_nxt;
    wire       clk_lvl_nxt;
    wire       slow_tick;
    wire       filt_lvl;
    wire       speed_lvl;
    wire       speed_rise;
    wire       speed_any;
    wire [3:0] edges_target;
    wire       wr_ctrl;
    wire       wr_status;
    wire       out_of_limit;

    assign wr_ctrl   = reg_wr_in && (reg_addr_in == `FSPD_OFS_CTRL);
    assign wr_status = reg_wr_in && (reg_addr_in == `FSPD_OFS_STATUS);

    // Three-stage sampling; a change counts once stages two and three agree.
    // Sampling stops while idle so the pins are not watched at all. [RULE2]
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            pin_sync_r <= 3'h0;
            clk_sync_r <= 3'h0;
            pin_lvl_r  <= 1'b0;
            clk_lvl_r  <= 1'b0;
        end else if (enable_r) begin
            pin_sync_r <= {pin_sync_r[1:0], speed_pin_in};
            clk_sync_r <= {clk_sync_r[1:0], count_clk_in};
            pin_lvl_r  <= pin_lvl_nxt;
            clk_lvl_r  <= clk_lvl_nxt;
        end
    end

    // Stage one is read only by stage two
    assign pin_lvl_nxt = (pin_sync_r[1] == pin_sync_r[2]) ? pin_sync_r[2] : pin_lvl_r;
    assign clk_lvl_nxt = (clk_sync_r[1] == clk_sync_r[2]) ? clk_sync_r[2] : clk_lvl_r;
    assign slow_tick   = enable_r && clk_lvl_nxt && !clk_lvl_r;

    // Glitch filter on the slow count clock [RULE5]
    fspd_glitch_filter #(
        .TICKS     (FILT_TICKS)
    ) u_filter (
        .core_clk_in (core_clk_in),
        .srst_in     (srst_in),
        .run_in      (enable_r),
        .tick_in     (slow_tick),
        .level_in    (pin_lvl_r),
        .level_out   (filt_lvl)
    );

    // Filter is bypassed when disabled [RULE5]
    assign speed_lvl  = filter_r ? filt_lvl : pin_lvl_r;
    assign speed_rise = enable_r && speed_lvl && !speed_prev_r;
    assign speed_any  = enable_r && (speed_lvl != speed_prev_r);

    always @(posedge core_clk_in) begin
        if (srst_in) begin
            speed_prev_r <= 1'b0;
        end else if (enable_r) begin
            speed_prev_r <= speed_lvl;
        end
    end

    // Interval length lookup [RULE8]
    assign edges_target = (edges_r == 2'b00) ? `FSPD_EDGES_C0 :
                          (edges_r == 2'b01) ? `FSPD_EDGES_C1 :
                          (edges_r == 2'b10) ? `FSPD_EDGES_C2 : `FSPD_EDGES_C3;

    // Counter, edge tally and reading; all frozen while idle [RULE3]
    always @* begin
        count_nxt     = count_r;
        reading_nxt   = reading_r;
        edge_seen_nxt = edge_seen_r;
        latch_evt     = 1'b0;
        if (enable_r) begin
            if (!mode_r) begin
                // Edge-count mode: reading follows every increment, wraps [RULE6] [RULE9]
                if (speed_rise) begin
                    count_nxt   = count_r + 16'h0001;
                    reading_nxt = count_r + 16'h0001;
                    latch_evt   = 1'b1;
                end
            end else begin
                // Clock-count mode; the closing edge also opens the next interval
                if (speed_any) begin
                    edge_seen_nxt = edge_seen_r + 4'h1;
                end
                if (speed_any && (edge_seen_r + 4'h1 >= edges_target)) begin
                    reading_nxt   = count_r;                       // [RULE7]
                    count_nxt     = `FSPD_RST_COUNT;
                    edge_seen_nxt = 4'h1;
                    latch_evt     = 1'b1;
                end else if (count_r == `FSPD_CNT_MAX) begin
                    // Saturated before enough edges: report FFFFh and restart [RULE10]
                    reading_nxt   = count_r;
                    count_nxt     = `FSPD_RST_COUNT;
                    edge_seen_nxt = 4'h0;
                    latch_evt     = 1'b1;
                end else if (slow_tick) begin
                    count_nxt = count_r + 16'h0001;                // [RULE7]
                end
            end
        end
    end

    always @(posedge core_clk_in) begin
        if (srst_in) begin
            count_r     <= `FSPD_RST_COUNT;                       // [RULE21]
            reading_r   <= `FSPD_RST_COUNT;
            edge_seen_r <= 4'h0;
        end else begin
            count_r     <= count_nxt;
            reading_r   <= reading_nxt;
            edge_seen_r <= edge_seen_nxt;
        end
    end

    // Limits are judged on the freshly latched value; FFFFh high and 0000h low
    // can never trip because no reading lies outside them [RULE17] [RULE19]
    assign out_of_limit = latch_evt && ((reading_nxt > high_r) || (reading_nxt < low_r));

    // Control and limit registers
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            limit_ie_r  <= 1'b0;                                   // [RULE21]
            enable_r    <= 1'b0;
            filter_r    <= 1'b0;
            mode_r      <= 1'b0;
            edges_r     <= 2'b00;
            ready_ie_r  <= 1'b0;
            toggle_ie_r <= 1'b0;
            high_r      <= `FSPD_RST_HIGH;
            low_r       <= `FSPD_RST_LOW;
        end else begin
            if (wr_ctrl) begin
                limit_ie_r  <= reg_wdata_in[`FSPD_CTL_LIMIT_IE];
                enable_r    <= reg_wdata_in[`FSPD_CTL_ENABLE];     // [RULE2]
                filter_r    <= reg_wdata_in[`FSPD_CTL_FILTER];
                mode_r      <= reg_wdata_in[`FSPD_CTL_MODE];
                edges_r     <= reg_wdata_in[`FSPD_CTL_EDGES_HI:`FSPD_CTL_EDGES_LO];
                ready_ie_r  <= reg_wdata_in[`FSPD_CTL_READY_IE];
                toggle_ie_r <= reg_wdata_in[`FSPD_CTL_TOGGLE_IE];
            end
            if (reg_wr_in && (reg_addr_in == `FSPD_OFS_HIGH)) begin
                high_r <= reg_wdata_in[15:0];                      // [RULE17]
            end
            if (reg_wr_in && (reg_addr_in == `FSPD_OFS_LOW)) begin
                low_r <= reg_wdata_in[15:0];                       // [RULE19]
            end
        end
    end

    // Sticky status; a new event in the clearing cycle wins over the clear.
    // Nothing here is cleared by disabling, so stale events stay pending. [RULE3]
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            st_limit_r  <= 1'b0;                                   // [RULE21]
            st_toggle_r <= 1'b0;
            st_ready_r  <= 1'b0;
        end else begin
            if (out_of_limit) begin
                st_limit_r <= 1'b1;                                // [RULE12] [RULE19]
            end else if (wr_status && reg_wdata_in[`FSPD_ST_LIMIT]) begin
                st_limit_r <= 1'b0;                                // [RULE12]
            end
            if (speed_any) begin
                st_toggle_r <= 1'b1;                               // [RULE14]
            end else if (wr_status && reg_wdata_in[`FSPD_ST_TOGGLE]) begin
                st_toggle_r <= 1'b0;                               // [RULE14]
            end
            if (!mode_r) begin
                st_ready_r <= 1'b0;                                // [RULE15]
            end else if (latch_evt) begin
                st_ready_r <= 1'b1;                                // [RULE16]
            end else if (wr_status && reg_wdata_in[`FSPD_ST_READY]) begin
                st_ready_r <= 1'b0;                                // [RULE16]
            end
        end
    end

    // Interrupt and pin buffer enable, both registered
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            irq_out          <= 1'b0;
            speed_pin_ie_out <= 1'b0;
        end else begin
            irq_out <= (st_limit_r && limit_ie_r) ||               // [RULE1] [RULE20]
                       (st_toggle_r && toggle_ie_r) ||             // [RULE14] [RULE20]
                       (st_ready_r && ready_ie_r);                 // [RULE16] [RULE20]
            speed_pin_ie_out <= enable_r;                          // [RULE2]
        end
    end

    // Read port: one cycle latency, unmapped offsets read zero.
    // A read has no side effect, so the counter keeps running. [RULE9]
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            reg_rdata_out  <= 32'h0000_0000;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            reg_rdata_out  <= 32'h0000_0000;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    `FSPD_OFS_CTRL: begin
                        reg_rdata_out <= {reading_r, toggle_ie_r, ready_ie_r, 1'b0,
                                          edges_r, mode_r, 1'b0, filter_r,
                                          6'h00, enable_r, limit_ie_r};
                    end
                    `FSPD_OFS_STATUS: begin
                        reg_rdata_out <= {28'h0000000, st_ready_r, st_toggle_r,
                                          speed_lvl, st_limit_r};  // [RULE13]
                    end
                    `FSPD_OFS_HIGH: begin
                        reg_rdata_out <= {16'h0000, high_r};
                    end
                    `FSPD_OFS_LOW: begin
                        reg_rdata_out <= {16'h0000, low_r};
                    end
                    default: begin
                        reg_rdata_out <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end
endmodule // fspd_monitor
